// File: inc/cwd_defines.vh
// Summary of operation
// - code_protect 1 disables protection, 0 enables
// - low_voltage_prog 1 ignores reset_pin_select
// - reset_pin_select 1: master clear, pull-up on
// - reset_pin_select 0: input, pull-up follows enable
// - powerup_timer_enable is active low
// - watchdog_mode 11 always on, 10 awake only
// - watchdog_mode 01 software bit, 00 off
// - osc_select 111/110/101 external clock ranges
// - osc_select 100 internal, 011 external rc
// - osc_select 010/001/000 crystal modes
// - program erase or bulk erase wipes memory
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CWD_OFS_WORD_ONE 4'h0
`define CWD_OFS_WORD_TWO 4'h4
`define CWD_OFS_CONTROL 4'h8
`define CWD_OFS_STATUS 4'hc
// ----------------------------------------
// word one field positions
// ----------------------------------------
`define CWD_PROT_BIT 7
`define CWD_RPS_BIT 6
`define CWD_PUT_BIT 5
`define CWD_WDM_HI 4
`define CWD_WDM_LO 3
`define CWD_OSC_HI 2
`define CWD_OSC_LO 0
// ----------------------------------------
// word two field positions
// ----------------------------------------
`define CWD_LOWV_BIT 13
`define CWD_DEBUG_BIT 12
// implemented mask of word two, others read as one
`define CWD_W2_IMPL 14'h3f83
// ----------------------------------------
// reset and erased values
// ----------------------------------------
`define CWD_ERASED 14'h3fff
// ----------------------------------------
// control bits
// ----------------------------------------
`define CWD_CTL_SWDT 0
`define CWD_CTL_PULLUP 1
`define CWD_CTL_SLEEP 2
`define CWD_CTL_ERASE_PM 3
`define CWD_CTL_BULK 4
// ----------------------------------------
// watchdog and oscillator codes
// ----------------------------------------
`define CWD_WDM_ON 2'h3
`define CWD_WDM_AWAKE 2'h2
`define CWD_WDM_SOFT 2'h1
`define CWD_OSC_EXT_HI 3'h7
`define CWD_OSC_EXT_MID 3'h6
`define CWD_OSC_EXT_LO 3'h5
`define CWD_OSC_INT 3'h4
`define CWD_OSC_RC 3'h3
`define CWD_OSC_XTAL_FAST 3'h2
`define CWD_OSC_XTAL_STD 3'h1
`define CWD_OSC_XTAL_SLOW 3'h0
// ----------------------------------------
// response codes
// ----------------------------------------
`define CWD_RESP_OKAY 2'h0
`define CWD_RESP_SLVERR 2'h2
`endif

// File: rtl/cwd_config_word_decoder.v
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "cwd_defines.vh"
module cwd_config_word_decoder (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// nonvolatile storage image
	input wire [13:0] nv_word_one_i,
	input wire [13:0] nv_word_two_i,
	// erase strobes to storage
	output reg erase_program_o,
	output reg erase_config_o,
	// decoded settings
	output reg protect_active_o,
	output reg master_clear_en_o,
	output reg pin_pullup_o,
	output reg powerup_timer_en_o,
	output reg watchdog_run_o,
	output reg [2:0] osc_mode_o,
	output reg ext_clock_o,
	output reg internal_osc_o,
	output reg clock_pin_io_o,
	output reg external_rc_o,
	output reg crystal_drive_o,
	// axi4-lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

// ----------------------------------------
// state
// ----------------------------------------
localparam ST_LOAD = 1'b0;
localparam ST_RUN = 1'b1;

reg state_reg;
reg [13:0] sync1_one_reg;
reg [13:0] sync2_one_reg;
reg [13:0] sync1_two_reg;
reg [13:0] sync2_two_reg;
reg [13:0] word_one_reg;
reg [13:0] word_two_reg;
reg [2:0] ctl_reg;
reg [3:0] aw_addr_reg;
reg aw_have_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_have_reg;

// decode of the latched words
wire low_v = word_two_reg[`CWD_LOWV_BIT];
wire [1:0] wdm = word_one_reg[`CWD_WDM_HI:`CWD_WDM_LO];
wire [2:0] osc = word_one_reg[`CWD_OSC_HI:`CWD_OSC_LO];
// low-voltage mode overrides the pin select bit
wire rst_pin_sel = ~low_v & word_one_reg[`CWD_RPS_BIT];
reg wd_run;

// ----------------------------------------
// functions
// ----------------------------------------
// read-back view of word two, unimplemented bits forced to one
function [13:0] view_two;
	input [13:0] w;
	begin
		view_two = w | ~`CWD_W2_IMPL;
	end
endfunction

// word-aligned byte address, low two bits dropped
function [3:0] word_addr;
	input [3:0] a;
	begin
		word_addr = {a[3:2], 2'b00};
	end
endfunction

// external clock fed on the clock-in pin
function osc_is_ext;
	input [2:0] c;
	begin
		case (c)
			`CWD_OSC_EXT_HI: osc_is_ext = 1'b1;
			`CWD_OSC_EXT_MID: osc_is_ext = 1'b1;
			`CWD_OSC_EXT_LO: osc_is_ext = 1'b1;
			default: osc_is_ext = 1'b0;
		endcase
	end
endfunction

// crystal or resonator across both oscillator pins
function osc_is_xtal;
	input [2:0] c;
	begin
		case (c)
			`CWD_OSC_XTAL_FAST: osc_is_xtal = 1'b1;
			`CWD_OSC_XTAL_STD: osc_is_xtal = 1'b1;
			`CWD_OSC_XTAL_SLOW: osc_is_xtal = 1'b1;
			default: osc_is_xtal = 1'b0;
		endcase
	end
endfunction

// watchdog run from mode, software bit and sleep
always @* begin
	case (wdm)
		`CWD_WDM_ON: wd_run = 1'b1;
		`CWD_WDM_AWAKE: wd_run = ~ctl_reg[`CWD_CTL_SLEEP];
		`CWD_WDM_SOFT: wd_run = ctl_reg[`CWD_CTL_SWDT];
		default: wd_run = 1'b0;
	endcase
end

// ----------------------------------------
// storage sampling and latch at reset
// ----------------------------------------
// storage pins come from outside, two flops first
always @(posedge clk_i) begin
	sync1_one_reg <= nv_word_one_i;
	sync2_one_reg <= sync1_one_reg;
	sync1_two_reg <= nv_word_two_i;
	sync2_two_reg <= sync1_two_reg;
end

// words load once after reset, then stay fixed
always @(posedge clk_i) begin
	if (rst_i) begin
		state_reg <= ST_LOAD;
		word_one_reg <= `CWD_ERASED;
		word_two_reg <= `CWD_ERASED;
	end else begin
		case (state_reg)
			ST_LOAD: begin
				word_one_reg <= sync2_one_reg;
				word_two_reg <= view_two(sync2_two_reg);
				state_reg <= ST_RUN;
			end
			ST_RUN: state_reg <= ST_RUN;
			default: state_reg <= ST_LOAD;
		endcase
	end
end

// ----------------------------------------
// protection and reset pin outputs
// ----------------------------------------
// protection and pin function follow the latched words
always @(posedge clk_i) begin
	if (rst_i) begin
		protect_active_o <= 1'b0;
		master_clear_en_o <= 1'b0;
		pin_pullup_o <= 1'b0;
	end else begin
		protect_active_o <= ~word_one_reg[`CWD_PROT_BIT];
		master_clear_en_o <= rst_pin_sel;
		// pull-up on in reset mode, else from the enable bit
		pin_pullup_o <= rst_pin_sel | ctl_reg[`CWD_CTL_PULLUP];
	end
end

// ----------------------------------------
// timer and watchdog outputs
// ----------------------------------------
// timer enable is inverted, watchdog may follow sleep
always @(posedge clk_i) begin
	if (rst_i) begin
		powerup_timer_en_o <= 1'b0;
		watchdog_run_o <= 1'b0;
	end else begin
		powerup_timer_en_o <= ~word_one_reg[`CWD_PUT_BIT];
		watchdog_run_o <= wd_run;
	end
end

// ----------------------------------------
// oscillator outputs
// ----------------------------------------
// out of reset, exactly one clock source class is flagged at a time; in reset none is
always @(posedge clk_i) begin
	if (rst_i) begin
		osc_mode_o <= `CWD_OSC_EXT_HI;
		ext_clock_o <= 1'b0;
		internal_osc_o <= 1'b0;
		clock_pin_io_o <= 1'b0;
		external_rc_o <= 1'b0;
		crystal_drive_o <= 1'b0;
	end else begin
		osc_mode_o <= osc;
		ext_clock_o <= osc_is_ext(osc);
		// internal source frees the clock-in pin
		internal_osc_o <= (osc == `CWD_OSC_INT);
		clock_pin_io_o <= (osc == `CWD_OSC_INT);
		external_rc_o <= (osc == `CWD_OSC_RC);
		crystal_drive_o <= osc_is_xtal(osc);
	end
end

// ----------------------------------------
// status word
// ----------------------------------------
// status byte gathers the decoded outputs for software
wire [7:0] status_byte = {watchdog_run_o, master_clear_en_o,
	pin_pullup_o, powerup_timer_en_o, protect_active_o, osc_mode_o};

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
wire do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
wire ctl_hit = (aw_addr_reg == `CWD_OFS_CONTROL);
wire st_hit = (aw_addr_reg == `CWD_OFS_STATUS);
wire ctl_write = do_write & ctl_hit & w_strb_reg[0];

// address and data handshakes, then one response
always @(posedge clk_i) begin
	if (rst_i) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CWD_RESP_OKAY;
		aw_have_reg <= 1'b0;
		w_have_reg <= 1'b0;
		aw_addr_reg <= 4'h0;
		w_data_reg <= 32'h0;
		w_strb_reg <= 4'h0;
	end else begin
		// address and data taken in either order
		if (s_axi_awvalid & s_axi_awready) begin
			aw_addr_reg <= word_addr(s_axi_awaddr);
			aw_have_reg <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
			w_have_reg <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (do_write) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			// config words are read only, writes there are refused
			if (ctl_hit | st_hit)
				s_axi_bresp <= `CWD_RESP_OKAY;
			else
				s_axi_bresp <= `CWD_RESP_SLVERR;
		end
		if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// ----------------------------------------
// control register and erase strobes
// ----------------------------------------
// control bits update on a write through byte lane zero
always @(posedge clk_i) begin
	if (rst_i) begin
		ctl_reg <= 3'h0;
		erase_program_o <= 1'b0;
		erase_config_o <= 1'b0;
	end else begin
		// strobes last one cycle unless written again
		erase_program_o <= 1'b0;
		erase_config_o <= 1'b0;
		if (ctl_write) begin
			ctl_reg <= w_data_reg[2:0];
			// the program-erase bit or the bulk bit wipes program memory
			erase_program_o <= w_data_reg[`CWD_CTL_ERASE_PM] |
				w_data_reg[`CWD_CTL_BULK];
			// bulk erase also wipes configuration memory
			erase_config_o <= w_data_reg[`CWD_CTL_BULK];
		end
	end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0;
		s_axi_rresp <= `CWD_RESP_OKAY;
	end else begin
		if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `CWD_RESP_OKAY;
			case (word_addr(s_axi_araddr))
				`CWD_OFS_WORD_ONE: s_axi_rdata <= {18'h0, word_one_reg};
				`CWD_OFS_WORD_TWO: s_axi_rdata <= {18'h0, word_two_reg};
				`CWD_OFS_CONTROL: s_axi_rdata <= {29'h0, ctl_reg};
				`CWD_OFS_STATUS: s_axi_rdata <= {24'h0, status_byte};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `CWD_RESP_SLVERR;
				end
			endcase
		end
		if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule

// File: tb/cwd_prog_tool_model.sv
`timescale 1ns/1ps
module cwd_prog_tool_model (
	// clock
	input wire clk_i,
	// words written by the tool
	input wire prog_i,
	input wire [13:0] data_one_i,
	input wire [13:0] data_two_i,
	// erase strobes from the device
	input wire erase_program_i,
	input wire erase_config_i,
	// stored image and erase tally
	output reg [13:0] word_one_o = 14'h3fff,
	output reg [13:0] word_two_o = 14'h3fff,
	output reg [3:0] prog_erase_cnt_o = 4'h0
);
	// program, or erase back to all ones
	always @(posedge clk_i) begin
		if (erase_program_i)
			prog_erase_cnt_o <= prog_erase_cnt_o + 4'h1;
		if (erase_config_i) begin
			word_one_o <= 14'h3fff;
			word_two_o <= 14'h3fff;
		end else if (prog_i) begin
			word_one_o <= data_one_i;
			word_two_o <= data_two_i | 14'h1000;
		end
	end
endmodule

// File: tb/cwd_checker.sv
`timescale 1ns/1ps
module cwd_checker (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// watched outputs
	input wire erase_program_o,
	input wire erase_config_o,
	input wire protect_active_o,
	input wire master_clear_en_o,
	input wire pin_pullup_o,
	input wire [2:0] osc_mode_o,
	input wire ext_clock_o,
	input wire internal_osc_o,
	input wire clock_pin_io_o,
	input wire external_rc_o,
	input wire crystal_drive_o
);
	reg [1:0] age_reg;
	// cycles since reset release, saturating
	always @(posedge clk_i) begin
		if (rst_i)
			age_reg <= 2'h0;
		else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ext_clock: assert property (
		age_reg == 2'h3 |-> ext_clock_o == (osc_mode_o >= 3'h5))
		else $error("ext clock flag bad");
	chk_int_osc: assert property (
		age_reg == 2'h3 |-> internal_osc_o == (osc_mode_o == 3'h4)
		&& clock_pin_io_o == internal_osc_o) else $error("int osc bad");
	chk_ext_rc: assert property (
		age_reg == 2'h3 |-> external_rc_o == (osc_mode_o == 3'h3))
		else $error("rc flag bad");
	chk_crystal_mode: assert property (
		age_reg == 2'h3 |-> crystal_drive_o == (osc_mode_o < 3'h3))
		else $error("crystal flag bad");
	chk_reset_pullup: assert property (
		age_reg == 2'h3 && master_clear_en_o |-> pin_pullup_o)
		else $error("pull-up off in reset mode");
	chk_held_stable: assert property (
		age_reg == 2'h3 |=> $stable({protect_active_o, osc_mode_o}))
		else $error("latched field moved");
	chk_bulk_both: assert property (
		erase_config_o |-> erase_program_o) else $error("bulk erase half");
	chk_erase_pulse: assert property (
		$rose(erase_program_o) |=> !erase_program_o)
		else $error("erase pulse too long");
endmodule
bind cwd_config_word_decoder cwd_checker u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .erase_program_o(erase_program_o),
	.erase_config_o(erase_config_o), .protect_active_o(protect_active_o),
	.master_clear_en_o(master_clear_en_o), .pin_pullup_o(pin_pullup_o),
	.osc_mode_o(osc_mode_o), .ext_clock_o(ext_clock_o),
	.internal_osc_o(internal_osc_o), .clock_pin_io_o(clock_pin_io_o),
	.external_rc_o(external_rc_o), .crystal_drive_o(crystal_drive_o));

// File: tb/config_word_decoder_tb_top.sv
`timescale 1ns/1ps
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin n_fail++; \
$display("[ERR] %0t %h %h", $time, a, b); end end
module config_word_decoder_tb_top;
	reg clk_i = 0, rst_i = 1, pg = 0, awv = 0, wv = 0, bre = 0, arv = 0;
	reg rre = 0;
	reg [13:0] p1 = 0, p2 = 0, a1, a2;
	reg [3:0] aw = 0, ar = 0;
	reg [31:0] wd = 0, d;
	reg [1:0] r;
	wire [13:0] w1, w2;
	wire [3:0] npe;
	wire ep, ec, awr, wrd, bv, arr, rv;
	wire [1:0] br, rr;
	wire [31:0] rd;
	int n_fail = 0, checked = 0, k, i, c;
	always #50 clk_i = ~clk_i;
	cwd_prog_tool_model nv (.clk_i(clk_i), .prog_i(pg), .data_one_i(p1),
		.data_two_i(p2), .erase_program_i(ep), .erase_config_i(ec),
		.word_one_o(w1), .word_two_o(w2), .prog_erase_cnt_o(npe));
	cwd_config_word_decoder dut (.clk_i(clk_i), .rst_i(rst_i),
		.nv_word_one_i(w1), .nv_word_two_i(w2), .erase_program_o(ep),
		.erase_config_o(ec), .protect_active_o(), .master_clear_en_o(),
		.pin_pullup_o(), .powerup_timer_en_o(), .watchdog_run_o(),
		.osc_mode_o(), .ext_clock_o(), .internal_osc_o(),
		.clock_pin_io_o(), .external_rc_o(), .crystal_drive_o(),
		.s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre));
	// counts and verdict
	task finish_test;
		$display("checks %0d fails %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one write, response code in r
	task wr(input [3:0] a, input [31:0] v);
		@(posedge clk_i);
		aw <= a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_i);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
			if (bv) break;
		end
		r = br; bre <= 0; awv <= 0; wv <= 0;
		if (k == 50) begin n_fail++; finish_test; end
	endtask
	// one read, data in d and code in r
	task rdr(input [3:0] a);
		@(posedge clk_i);
		ar <= a; arv <= 1; rre <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_i);
			if (arr) arv <= 0;
			if (rv) break;
		end
		d = rd; r = rr; rre <= 0; arv <= 0;
		if (k == 50) begin n_fail++; finish_test; end
	endtask
	// reset, optionally programming new words meanwhile
	task boot(input [13:0] a, input [13:0] b, input bit p);
		@(posedge clk_i);
		rst_i <= 1; p1 <= a; p2 <= b; pg <= p;
		@(posedge clk_i);
		pg <= 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
	endtask
	// expected status byte from the words and control bits
	function [7:0] st(input [13:0] a, input [13:0] b, input [2:0] t);
		reg m;
		begin
			m = !b[13] && a[6];
			st = {a[4:3] == 3 || (a[4:3] == 2 && !t[2]) ||
				(a[4:3] == 1 && t[0]), m, m | t[1], !a[5], !a[7], a[2:0]};
		end
	endfunction
	// main sequence
	initial begin
		for (i = 0; i < 8; i++) begin
			a1 = {6'h3f, i[0], i[1], i[2], i[1:0], i[2:0]};
			a2 = i[2] ? 14'h3f83 : 14'h1f03;
			boot(a1, a2, 1);
			rdr(4'h0); `CHK(d[13:0], a1)
			rdr(4'h4); `CHK(d[13:0], a2 | 14'h107c)
			for (c = 0; c < 8; c++) begin
				wr(4'h8, c);
				rdr(4'hc); `CHK(d[7:0], st(a1, a2, c[2:0]))
			end
			$display("config set %0d done", i);
		end
		wr(4'h0, 32'h0); `CHK(r, 2'h2)
		rdr(4'h2); `CHK({r, d[13:0]}, {2'h0, a1})
		wr(4'h8, 32'h08); @(negedge clk_i); `CHK(npe, 4'h1)
		rdr(4'h0); `CHK(d[13:0], a1)
		wr(4'h8, 32'h10); @(negedge clk_i); `CHK(npe, 4'h2)
		rdr(4'h0); `CHK(d[13:0], a1)
		boot(a1, a2, 0);
		rdr(4'h0); `CHK(d[13:0], 14'h3fff)
		$display("erase test done");
		finish_test;
	end
endmodule
